// ===== logic/ccc_defs.vh
`ifndef CCC_DEFS_VH
`define CCC_DEFS_VH

// ==========================================================
// Register offsets
`define CCC_OFS_FRACTION      16'hff60
`define CCC_OFS_SECONDS       16'hff62
`define CCC_OFS_MINUTES       16'hff63
`define CCC_OFS_HOURS         16'hff64
`define CCC_OFS_WEEKDAY       16'hff65
`define CCC_OFS_DAY           16'hff66
`define CCC_OFS_CONTROL       16'hff8b

// ==========================================================
// Reset values
`define CCC_RST_FRACTION      16'h0000
`define CCC_RST_SECONDS       8'h00
`define CCC_RST_MINUTES       8'h00
`define CCC_RST_HOURS_12      8'h12
`define CCC_RST_HOURS_24      8'h00
`define CCC_RST_WEEKDAY       8'h00
`define CCC_RST_DAY           8'h01
`define CCC_RST_CONTROL       8'h00

// ==========================================================
// Control register fields
`define CCC_CTL_IRQ_EN_BIT    7
`define CCC_CTL_DIV_OE_BIT    6
`define CCC_CTL_FREQ_BIT      5
`define CCC_CTL_SEL_MSB       2
`define CCC_CTL_SEL_LSB       0
`define CCC_CTL_WR_MASK       8'he7

// ==========================================================
// Counter limits and timing
`define CCC_FRAC_TOP          16'h7fff
`define CCC_FRAC_MAX          16'hffff
`define CCC_SEL_BASE_EXP      6
`define CCC_SEL_MAX_EXP       12
`define CCC_DIV_BIT_512HZ     5
`define CCC_DIV_BIT_16KHZ     0
`define CCC_LS_CLOCK_HZ       32768
`define CCC_MCLK_HZ           100000000
`define CCC_WRITE_LAG_LS      2

`endif

// ===== logic/ccc_calendar_core.v
// Overview of operation
// RULE_01 - Interval interrupt only when enabled; select 0..7 gives 2^6..2^12, 6/7 same.
// RULE_02 - Software changes interval select only while interval interrupt is disabled.
// RULE_03 - Divided clock pin is driven only while its output enable is set.
// RULE_04 - Frequency select 0 gives 512 Hz, 1 gives 16.384 kHz on divided pin.
// RULE_05 - Software never enables 32 kHz output and divided output together.
// RULE_06 - Disabled divided output stops within two slow clocks, then holds low.
// RULE_07 - Fraction counter counts slow clock 0000 to 7fff; overflow marks one second.
// RULE_08 - Fraction counter holds values of 8000 and above after error correction.
// RULE_09 - Any seconds write clears the fraction counter.
// RULE_10 - Software reads fraction counter only while counting is halted.
// RULE_11 - Count writes pass through a buffer, reaching counter within two slow clocks.
// RULE_12 - Out-of-range BCD value returns to valid value within one count period.
// RULE_13 - Seconds hold BCD 0..59, bit 7 zero, count on fraction overflow, reset 00.
// RULE_14 - Minutes hold BCD 0..59, count on seconds wrap, reset 00.
// RULE_15 - Hours count on minutes wrap; 00..23, or 01..12 and 21..32 in 12-hour mode.
// RULE_16 - In 12-hour mode bit 5 of hours means afternoon when set.
// RULE_17 - Hours reset to 12; read 00 if 24-hour mode is chosen after reset.
// RULE_18 - Day counts on hours wrap, limit 31, 30, 29 or 28 by month and leap year.
// RULE_19 - Day holds BCD in bits 5..0, bits 7..6 zero, reset 01.
// RULE_20 - Weekday holds 0..6 in bits 2..0, reset 00, advances with the day.
// RULE_21 - Years 00, 04, 08 ... 96 are leap years for the February limit.
// RULE_22 - Software sets wait control and sees wait status before counter access.
// RULE_23 - Each counter rolls to its lowest value past its maximum and carries once.
// RULE_24 - Interval interrupt is a one-cycle pulse per completed division while enabled.
`default_nettype none
`include "ccc_defs.vh"

module ccc_calendar_core #(
	parameter SEL_WIDTH = 3
) (
	// Clock and reset
	input  wire        mclk,
	input  wire        rstn,
	// Slow reference clock pin
	input  wire        lsclk_pin,
	// CPU register port
	input  wire [15:0] bus_addr,
	input  wire        bus_wr,
	input  wire        bus_rd,
	input  wire [15:0] bus_wdata,
	output reg  [15:0] bus_rdata,
	// Controls held in neighbouring registers
	input  wire        hour_system_select,
	input  wire        counter_wait_control,
	output reg         counter_wait_status,
	input  wire [7:0]  month_bcd,
	input  wire [7:0]  year_bcd,
	input  wire        watch_error_correction,
	input  wire [15:0] correction_value,
	// Events and pins
	output reg         interval_irq,
	output reg         day_overflow,
	output reg         divided_clock_pin,
	output reg         divided_clock_pin_oe
);

	// ==========================================================
	// Helpers
	function [7:0] bcd_inc;
		input [7:0] v;
		begin
			if (v[3:0] >= 4'h9)
				bcd_inc = {v[7:4] + 4'h1, 4'h0};
			else
				bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	function bcd_ok;
		input [7:0] v;
		begin
			bcd_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9);
		end
	endfunction

	// ==========================================================
	// Slow clock synchroniser
	reg        ls_s1_reg;
	reg        ls_s2_reg;
	reg        ls_s3_reg;

	// Two flops before use, third only for the edge
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ls_s1_reg <= 1'b0;
			ls_s2_reg <= 1'b0;
			ls_s3_reg <= 1'b0;
		end else begin
			ls_s1_reg <= lsclk_pin;
			ls_s2_reg <= ls_s1_reg;
			ls_s3_reg <= ls_s2_reg;
		end
	end
	wire tick = ls_s2_reg & ~ls_s3_reg;

	// ==========================================================
	// Registers
	reg [15:0] frac_reg;
	reg        ovf_pend_reg;
	reg [7:0]  sec_reg;
	reg [7:0]  min_reg;
	reg [7:0]  hour_reg;
	reg [7:0]  wday_reg;
	reg [7:0]  day_reg;
	reg [7:0]  ctl_reg;
	reg        hour_fresh_reg;
	reg [11:0] presc_reg;
	reg [4:0]  pend_reg;
	reg [7:0]  wbuf_reg [0:4];
	wire [4:0] wr_hit;

	// Write buffer slots: 0 sec, 1 min, 2 hour, 3 weekday, 4 day
	assign wr_hit = {bus_wr && (bus_addr == `CCC_OFS_DAY),
	                 bus_wr && (bus_addr == `CCC_OFS_WEEKDAY),
	                 bus_wr && (bus_addr == `CCC_OFS_HOURS),
	                 bus_wr && (bus_addr == `CCC_OFS_MINUTES),
	                 bus_wr && (bus_addr == `CCC_OFS_SECONDS)};

	// ==========================================================
	// Fraction counter
	// RULE_07 - wrap at top
	wire frac_ovf = (frac_reg == `CCC_FRAC_TOP) || (frac_reg == `CCC_FRAC_MAX);

	// Keeps running under wait; an overflow then waits in ovf_pend
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			frac_reg     <= `CCC_RST_FRACTION;
			ovf_pend_reg <= 1'b0;
		end else if (tick && pend_reg[0]) begin
			// RULE_09 - seconds write clears
			frac_reg     <= `CCC_RST_FRACTION;
			ovf_pend_reg <= 1'b0;
		end else if (watch_error_correction) begin
			// RULE_08 - full 16 bits kept
			frac_reg <= correction_value;
		end else if (tick) begin
			frac_reg     <= frac_ovf ? 16'h0000 : frac_reg + 16'h0001;
			ovf_pend_reg <= (frac_ovf || ovf_pend_reg) && counter_wait_control;
		end
	end
	wire count_sec = tick && !counter_wait_control && (frac_ovf || ovf_pend_reg)
	                   && !pend_reg[0];

	// ==========================================================
	// Cascade next values
	reg [7:0] sec_nx;
	reg [7:0] min_nx;
	reg [7:0] hour_nx;
	reg [7:0] day_nx;
	reg [7:0] wday_nx;
	reg [7:0] day_lim;
	reg       sec_c;
	reg       min_c;
	reg       hour_c;
	reg       day_c;
	reg       leap;
	reg       h_ok;

	// RULE_23 - roll over and carry
	always @* begin
		// RULE_12 - bad value snaps to minimum
		// RULE_13 - seconds 00..59
		sec_c  = (sec_reg == 8'h59);
		sec_nx = (sec_reg >= 8'h59 || !bcd_ok(sec_reg)) ? 8'h00 : bcd_inc(sec_reg);
		// RULE_14 - minutes 00..59
		min_c  = (min_reg == 8'h59);
		min_nx = (min_reg >= 8'h59 || !bcd_ok(min_reg)) ? 8'h00 : bcd_inc(min_reg);
		// RULE_15 - hours in both systems
		hour_c  = 1'b0;
		hour_nx = bcd_inc(hour_reg);
		if (hour_system_select) begin
			h_ok = bcd_ok(hour_reg) && hour_reg < 8'h23;
			hour_c = (hour_reg == 8'h23);
			if (!h_ok)
				hour_nx = 8'h00;
		end else begin
			// RULE_16 - bit 5 marks afternoon
			h_ok = bcd_ok(hour_reg) && ((hour_reg >= 8'h01 && hour_reg <= 8'h12)
			       || (hour_reg >= 8'h21 && hour_reg <= 8'h32));
			case (hour_reg)
				8'h11: hour_nx = 8'h32;
				8'h12: hour_nx = 8'h01;
				8'h31: begin
					hour_nx = 8'h12;
					hour_c  = 1'b1;
				end
				8'h32: hour_nx = 8'h21;
				default: begin
					if (!h_ok)
						hour_nx = 8'h12;
				end
			endcase
		end
		// RULE_21 - leap on multiples of four
		leap = year_bcd[4] ? (year_bcd[3:0] == 4'h2 || year_bcd[3:0] == 4'h6)
		                   : (year_bcd[3:0] == 4'h0 || year_bcd[3:0] == 4'h4
		                      || year_bcd[3:0] == 4'h8);
		// RULE_18 - month dependent limit
		case (month_bcd)
			8'h02: day_lim = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: day_lim = 8'h30;
			default: day_lim = 8'h31;
		endcase
		day_c  = (day_reg == day_lim);
		day_nx = (day_reg >= day_lim || day_reg == 8'h00 || !bcd_ok(day_reg))
		         ? `CCC_RST_DAY : bcd_inc(day_reg);
		// RULE_20 - weekday 0..6
		wday_nx = (wday_reg >= 8'h06) ? 8'h00 : wday_reg + 8'h01;
	end

	// ==========================================================
	// Time counters and write buffer
	integer i;

	// Buffered writes land on the next slow edge
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sec_reg        <= `CCC_RST_SECONDS;
			min_reg        <= `CCC_RST_MINUTES;
			hour_reg       <= `CCC_RST_HOURS_12;
			wday_reg       <= `CCC_RST_WEEKDAY;
			day_reg        <= `CCC_RST_DAY;
			hour_fresh_reg <= 1'b1;
			day_overflow   <= 1'b0;
			pend_reg       <= 5'h00;
			for (i = 0; i < 5; i = i + 1)
				wbuf_reg[i] <= 8'h00;
		end else begin
			day_overflow <= 1'b0;
			// RULE_11 - capture into buffer
			for (i = 0; i < 5; i = i + 1) begin
				if (wr_hit[i])
					wbuf_reg[i] <= bus_wdata[7:0];
			end
			pend_reg <= (tick ? 5'h00 : pend_reg) | wr_hit;
			// RULE_17 - 24-hour mode shows 00
			if (hour_fresh_reg && hour_system_select) begin
				hour_reg       <= `CCC_RST_HOURS_24;
				hour_fresh_reg <= 1'b0;
			end
			if (count_sec) begin
				sec_reg <= sec_nx;
				if (sec_c) begin
					min_reg <= min_nx;
					if (min_c) begin
						hour_reg       <= hour_nx;
						hour_fresh_reg <= 1'b0;
						// RULE_20 - weekday follows day
						if (hour_c) begin
							day_reg      <= day_nx;
							wday_reg     <= wday_nx;
							day_overflow <= day_c;
						end
					end
				end
			end
			// RULE_11 - buffer to counter
			if (tick) begin
				// RULE_13 - bit 7 forced low
				if (pend_reg[0])
					sec_reg <= {1'b0, wbuf_reg[0][6:0]};
				if (pend_reg[1])
					min_reg <= {1'b0, wbuf_reg[1][6:0]};
				if (pend_reg[2]) begin
					hour_reg       <= {2'b00, wbuf_reg[2][5:0]};
					hour_fresh_reg <= 1'b0;
				end
				if (pend_reg[3])
					wday_reg <= {5'h00, wbuf_reg[3][2:0]};
				// RULE_19 - bits 7..6 zero
				if (pend_reg[4])
					day_reg <= {2'b00, wbuf_reg[4][5:0]};
			end
		end
	end

	// ==========================================================
	// Wait status
	// Halt becomes visible at the next slow edge, release at once
	always @(posedge mclk or negedge rstn) begin
		if (!rstn)
			counter_wait_status <= 1'b0;
		else if (!counter_wait_control)
			counter_wait_status <= 1'b0;
		else if (tick)
			counter_wait_status <= 1'b1;
	end

	// ==========================================================
	// Control register and prescaler
	reg [11:0] sel_mask;
	reg        div_src;

	wire [SEL_WIDTH-1:0] sel = ctl_reg[`CCC_CTL_SEL_MSB:`CCC_CTL_SEL_LSB];

	// Unused bits 4..3 are held at zero
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			ctl_reg   <= `CCC_RST_CONTROL;
			presc_reg <= 12'h000;
		end else begin
			if (bus_wr && bus_addr == `CCC_OFS_CONTROL)
				ctl_reg <= bus_wdata[7:0] & `CCC_CTL_WR_MASK;
			if (tick)
				presc_reg <= presc_reg + 12'h001;
		end
	end

	// RULE_01 - period select, 6 and 7 alike
	always @* begin
		case (sel)
			3'h0: sel_mask = 12'h03f;
			3'h1: sel_mask = 12'h07f;
			3'h2: sel_mask = 12'h0ff;
			3'h3: sel_mask = 12'h1ff;
			3'h4: sel_mask = 12'h3ff;
			3'h5: sel_mask = 12'h7ff;
			default: sel_mask = 12'hfff;
		endcase
		// RULE_04 - 512 Hz or 16.384 kHz
		div_src = ctl_reg[`CCC_CTL_FREQ_BIT] ? presc_reg[`CCC_DIV_BIT_16KHZ]
		                                     : presc_reg[`CCC_DIV_BIT_512HZ];
	end

	// ==========================================================
	// Interrupt pulse and divided pin
	// Pin takes divider values on slow edges; a stop drives it low at the next mclk edge
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			interval_irq         <= 1'b0;
			divided_clock_pin    <= 1'b0;
			divided_clock_pin_oe <= 1'b0;
		end else begin
			// RULE_24 - one pulse per period
			interval_irq <= tick && ctl_reg[`CCC_CTL_IRQ_EN_BIT]
			                && ((presc_reg & sel_mask) == sel_mask);
			// RULE_03 - drive only when enabled
			divided_clock_pin_oe <= ctl_reg[`CCC_CTL_DIV_OE_BIT];
			// RULE_06 - low once disabled
			if (!ctl_reg[`CCC_CTL_DIV_OE_BIT])
				divided_clock_pin <= 1'b0;
			else if (tick)
				divided_clock_pin <= div_src;
		end
	end

	// ==========================================================
	// Read port
	// Fraction read live; it keeps counting even while halted
	always @(posedge mclk or negedge rstn) begin
		if (!rstn)
			bus_rdata <= 16'h0000;
		else if (bus_rd) begin
			case (bus_addr)
				`CCC_OFS_FRACTION: bus_rdata <= frac_reg;
				`CCC_OFS_SECONDS:  bus_rdata <= {8'h00, sec_reg};
				`CCC_OFS_MINUTES:  bus_rdata <= {8'h00, min_reg};
				`CCC_OFS_HOURS:    bus_rdata <= {8'h00, hour_reg};
				`CCC_OFS_WEEKDAY:  bus_rdata <= {8'h00, wday_reg};
				`CCC_OFS_DAY:      bus_rdata <= {8'h00, day_reg};
				`CCC_OFS_CONTROL:  bus_rdata <= {8'h00, ctl_reg};
				default:           bus_rdata <= 16'h0000;
			endcase
		end
	end

endmodule
`default_nettype wire

// ===== tb/ccc_core_properties.sv
`default_nettype none
`include "ccc_defs.vh"

module ccc_core_properties (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        rstn,
	// Register port
	input wire logic [15:0] bus_addr,
	input wire logic        bus_wr,
	input wire logic        bus_rd,
	input wire logic [15:0] bus_wdata,
	input wire logic [15:0] bus_rdata,
	// Wait handshake
	input wire logic        counter_wait_control,
	input wire logic        counter_wait_status,
	// Events and pin
	input wire logic        interval_irq,
	input wire logic        day_overflow,
	input wire logic        divided_clock_pin,
	input wire logic        divided_clock_pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;

	logic irq_en_reg;

	// ==========
	// Enable mirror; a pulse already in flight may trail a disable
	always @(posedge mclk or negedge rstn) begin
		if (!rstn)
			irq_en_reg <= 1'b0;
		else if (bus_wr && bus_addr == `CCC_OFS_CONTROL)
			irq_en_reg <= bus_wdata[`CCC_CTL_IRQ_EN_BIT];
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);

	// ==========
	// Event outputs
	irq_pulse_a: assert property (interval_irq |=> !interval_irq)
		else $error("interval pulse too long");
	irq_gated_a: assert property (interval_irq |-> irq_en_reg || $past(irq_en_reg)
		|| $past(irq_en_reg, 2)) else $error("interval pulse while disabled");
	ovf_pulse_a: assert property (day_overflow |=> !day_overflow)
		else $error("day carry too long");

	// ==========
	// Divided clock pin
	pin_gated_a: assert property (divided_clock_pin |-> divided_clock_pin_oe
		|| $past(divided_clock_pin_oe)) else $error("pin high while disabled");
	pin_idle_a: assert property (!divided_clock_pin_oe [*3] |-> !divided_clock_pin)
		else $error("pin not low after disable");

	// ==========
	// Read data fields and wait status release
	sec_bits_a: assert property (bus_rd && (bus_addr == `CCC_OFS_SECONDS
		|| bus_addr == `CCC_OFS_MINUTES) |=> bus_rdata[15:7] == 9'h000)
		else $error("seconds or minutes top bits set");
	day_bits_a: assert property (bus_rd && bus_addr == `CCC_OFS_DAY
		|=> bus_rdata[15:6] == 10'h000) else $error("day top bits set");
	week_bits_a: assert property (bus_rd && bus_addr == `CCC_OFS_WEEKDAY
		|=> bus_rdata[15:3] == 13'h0000) else $error("weekday top bits set");
	wait_drop_a: assert property (!counter_wait_control |=> !counter_wait_status)
		else $error("wait status stuck");
endmodule

`default_nettype wire

// ===== tb/calendar_counter_core_bench.sv
`default_nettype none
`include "ccc_defs.vh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
	$display("FAIL %s exp %0h got %0h", n, e, g); end end

module calendar_counter_core_bench;
	timeunit 1ns;
	timeprecision 1ps;

	// ==========
	// Stimulus and observed signals
	logic        mclk = 1'b0;
	logic        rstn = 1'b0;
	logic        lsclk_pin = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic        bus_wr = 1'b0;
	logic        bus_rd = 1'b0;
	logic [15:0] bus_wdata = 16'h0000;
	logic        hour_system_select = 1'b0;
	logic        counter_wait_control = 1'b0;
	logic [7:0]  month_bcd = 8'h01;
	logic [7:0]  year_bcd = 8'h01;
	logic        watch_error_correction = 1'b0;
	logic [15:0] correction_value = 16'h0000;
	wire logic [15:0] bus_rdata;
	wire logic   counter_wait_status;
	wire logic   interval_irq;
	wire logic   day_overflow;
	wire logic   divided_clock_pin;
	wire logic   divided_clock_pin_oe;
	int          fail_count = 0;
	int          tests_run = 0;
	int          tcnt = 0;
	int          cyc = 0;
	int          t0;
	int          ovf_cnt = 0;

	// Reference runs far faster than real so the run stays short
	always #5 mclk = ~mclk;
	always #20 lsclk_pin = ~lsclk_pin;
	always @(posedge lsclk_pin) tcnt++;
	always @(posedge mclk) cyc++;
	always @(posedge mclk) if (day_overflow === 1'b1) ovf_cnt++;

	ccc_calendar_core dut (
		.mclk(mclk), .rstn(rstn), .lsclk_pin(lsclk_pin),
		.bus_addr(bus_addr), .bus_wr(bus_wr), .bus_rd(bus_rd),
		.bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.hour_system_select(hour_system_select),
		.counter_wait_control(counter_wait_control),
		.counter_wait_status(counter_wait_status),
		.month_bcd(month_bcd), .year_bcd(year_bcd),
		.watch_error_correction(watch_error_correction),
		.correction_value(correction_value),
		.interval_irq(interval_irq), .day_overflow(day_overflow),
		.divided_clock_pin(divided_clock_pin),
		.divided_clock_pin_oe(divided_clock_pin_oe)
	);

	// ==========
	// Bus and timing helpers
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		#1;
		bus_addr = a;
		bus_wdata = {8'h00, d};
		bus_wr = 1'b1;
		@(posedge mclk);
		#1;
		bus_wr = 1'b0;
	endtask

	task automatic rdv(input logic [15:0] a, output logic [15:0] v);
		@(posedge mclk);
		#1;
		bus_addr = a;
		bus_rd = 1'b1;
		@(posedge mclk);
		#1;
		bus_rd = 1'b0;
		v = bus_rdata;
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] e);
		logic [15:0] v;
		rdv(a, v);
		`CHK("read data", e, v)
	endtask

	// Waits whole ticks, plus the synchroniser delay
	task automatic tk(input int n);
		repeat (n) @(posedge lsclk_pin);
		repeat (4) @(posedge mclk);
		#1;
	endtask

	task automatic load(input logic [15:0] v);
		@(posedge mclk);
		#1;
		correction_value = v;
		watch_error_correction = 1'b1;
		@(posedge mclk);
		#1;
		watch_error_correction = 1'b0;
	endtask

	task automatic wait_irq();
		int n;
		n = 0;
		while (interval_irq !== 1'b1 && n < 20000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		@(posedge mclk);
		#1;
	endtask

	// ==========
	// Scenarios
	task automatic t_reset();
		rd(`CCC_OFS_SECONDS, 16'h0000);
		rd(`CCC_OFS_MINUTES, 16'h0000);
		rd(`CCC_OFS_HOURS, 16'h0012);
		rd(`CCC_OFS_WEEKDAY, 16'h0000);
		rd(`CCC_OFS_DAY, 16'h0001);
		rd(`CCC_OFS_CONTROL, 16'h0000);
		rd(16'hff70, 16'h0000);
		hour_system_select = 1'b1;
		rstn = 1'b0;
		repeat (4) @(posedge mclk);
		#1;
		rstn = 1'b1;
		rd(`CCC_OFS_HOURS, 16'h0000);
		$display("test reset done");
	endtask

	// Loads sec/min/hour/day, forces one second, checks the cascade
	task automatic roll(input logic [31:0] w, input logic [7:0] mo, input logic [7:0] y,
		input logic [31:0] e, input logic [7:0] ew);
		logic [15:0] v;
		int          n0;
		month_bcd = mo;
		year_bcd = y;
		wr(`CCC_OFS_MINUTES, w[23:16]);
		wr(`CCC_OFS_HOURS, w[15:8]);
		wr(`CCC_OFS_DAY, w[7:0]);
		wr(`CCC_OFS_WEEKDAY, 8'h06);
		// Seconds last, so the fraction is read only a few ticks after its clear
		wr(`CCC_OFS_SECONDS, w[31:24]);
		tk(2);
		rd(`CCC_OFS_WEEKDAY, 16'h0006);
		rdv(`CCC_OFS_FRACTION, v);
		`CHK("fraction cleared", 1'b1, v < 16'h0004)
		n0 = ovf_cnt;
		load(16'h7ffe);
		tk(4);
		rd(`CCC_OFS_SECONDS, {8'h00, e[31:24]});
		rd(`CCC_OFS_MINUTES, {8'h00, e[23:16]});
		rd(`CCC_OFS_HOURS, {8'h00, e[15:8]});
		rd(`CCC_OFS_DAY, {8'h00, e[7:0]});
		rd(`CCC_OFS_WEEKDAY, {8'h00, ew});
		`CHK("day carry", (e[7:0] == 8'h01) ? 1 : 0, ovf_cnt - n0)
	endtask

	task automatic t_roll();
		roll(32'h59592328, 8'h02, 8'h01, 32'h00000001, 8'h00);
		roll(32'h59592328, 8'h02, 8'h04, 32'h00000029, 8'h00);
		roll(32'h59592330, 8'h04, 8'h01, 32'h00000001, 8'h00);
		roll(32'h59592330, 8'h01, 8'h01, 32'h00000031, 8'h00);
		hour_system_select = 1'b0;
		roll(32'h59591105, 8'h01, 8'h01, 32'h00003205, 8'h06);
		roll(32'h59593105, 8'h01, 8'h01, 32'h00001206, 8'h00);
		roll(32'h7a590505, 8'h01, 8'h01, 32'h00590505, 8'h06);
		$display("test cascade done");
	endtask

	task automatic t_wait();
		logic [15:0] v;
		counter_wait_control = 1'b1;
		tk(2);
		`CHK("wait status", 1'b1, counter_wait_status)
		load(16'h9000);
		rdv(`CCC_OFS_FRACTION, v);
		`CHK("fraction high", 1'b1, v >= 16'h9000 && v < 16'h9008)
		counter_wait_control = 1'b0;
		$display("test wait done");
	endtask

	task automatic t_div();
		for (int f = 0; f < 2; f++) begin
			wr(`CCC_OFS_CONTROL, f ? 8'h78 : 8'h58);
			rd(`CCC_OFS_CONTROL, f ? 16'h0060 : 16'h0040);
			`CHK("pin enable", 1'b1, divided_clock_pin_oe)
			@(posedge divided_clock_pin);
			t0 = cyc;
			@(posedge divided_clock_pin);
			`CHK("pin period", f ? 8 : 256, cyc - t0)
			wr(`CCC_OFS_CONTROL, 8'h00);
			tk(3);
			`CHK("pin off", 2'b00, {divided_clock_pin_oe, divided_clock_pin})
		end
		$display("test divided pin done");
	endtask

	task automatic t_irq();
		int n;
		n = 0;
		repeat (600) @(posedge mclk) if (interval_irq === 1'b1) n++;
		`CHK("irq while off", 0, n)
		for (int s = 0; s < 8; s++) if (s != 6) begin
			wr(`CCC_OFS_CONTROL, 8'(s));
			wr(`CCC_OFS_CONTROL, 8'h80 | 8'(s));
			wait_irq();
			t0 = tcnt;
			wait_irq();
			`CHK("interval ticks", (s > 5) ? 4096 : (64 << s), tcnt - t0)
			wr(`CCC_OFS_CONTROL, 8'h00);
		end
		$display("test interval done");
	endtask

	// ==========
	// Verdict, reached by the sequence or by the watchdog
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (4) @(posedge mclk);
		#1;
		rstn = 1'b1;
		t_reset();
		t_roll();
		t_wait();
		t_div();
		t_irq();
		wrap_up();
	end

	// Longest scenario needs about 66k cycles
	initial begin
		#950us;
		fail_count++;
		wrap_up();
	end
endmodule

bind ccc_calendar_core ccc_core_properties u_props (
	.mclk(mclk), .rstn(rstn), .bus_addr(bus_addr), .bus_wr(bus_wr),
	.bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
	.counter_wait_control(counter_wait_control),
	.counter_wait_status(counter_wait_status),
	.interval_irq(interval_irq), .day_overflow(day_overflow),
	.divided_clock_pin(divided_clock_pin),
	.divided_clock_pin_oe(divided_clock_pin_oe)
);

`default_nettype wire
